//--- ead_regs.svh
// Constants of the effective address decoder: mode codes, field positions and address steps.
`ifndef EAD_REGS_SVH
`define EAD_REGS_SVH

`define EAD_MODE_DREG    3'h0
`define EAD_MODE_AREG    3'h1
`define EAD_MODE_IND     3'h2
`define EAD_MODE_POSTINC 3'h3
`define EAD_MODE_PREDEC  3'h4
`define EAD_MODE_DISP    3'h5
`define EAD_MODE_INDEX   3'h6
`define EAD_MODE_SPEC    3'h7

`define EAD_SPEC_ABSW    3'h0
`define EAD_SPEC_ABSL    3'h1
`define EAD_SPEC_PCD     3'h2
`define EAD_SPEC_PCX     3'h3
`define EAD_SPEC_IMM     3'h4

`define EAD_SZ_BYTE      2'h0
`define EAD_SZ_WORD      2'h1
`define EAD_SZ_LONG      2'h2

`define EAD_MODE_HI      5
`define EAD_MODE_LO      3
`define EAD_REG_HI       2
`define EAD_REG_LO       0

`define EAD_X_AREG       15
`define EAD_X_REG_HI     14
`define EAD_X_REG_LO     12
`define EAD_X_LONG       11

`define EAD_SP_NUM       3'h7
`define EAD_STEP_B       32'h1
`define EAD_STEP_W       32'h2
`define EAD_STEP_L       32'h4
`define EAD_WORD_BYTES   32'h2

`endif

//--- ead_pkg.sv
// Types shared by the effective address decoder.
package ead_pkg;

  typedef enum logic [1:0] {
    EAD_ST_IDLE  = 2'h0,
    EAD_ST_FETCH = 2'h1,
    EAD_ST_CALC  = 2'h3
  } ead_state_e;

  typedef enum logic [2:0] {
    EAD_K_DREG = 3'h0,
    EAD_K_AREG = 3'h1,
    EAD_K_MEM  = 3'h2,
    EAD_K_IMM  = 3'h3,
    EAD_K_STAT = 3'h4,
    EAD_K_ILL  = 3'h5
  } ead_kind_e;

endpackage : ead_pkg

//--- ead_decoder.sv
// Effective address decoder: collects extension words and resolves one operand location.
`timescale 1ns/100ps
`default_nettype none
`include "ead_regs.svh"

// Operation
// RL1: Instructions span one to five words; length comes from the operation word alone.
// RL2: Each following word is either immediate data or an address extension.
// RL3: Writes always go to data space; reads are data unless mode says program.
// RL4: Address field is a 3-bit mode plus a 3-bit register number.
// RL5: Register direct modes pick one of 16 data or address registers.
// RL6: Indirect, displacement, index, absolute are data references, program for jumps.
// RL7: Postincrement uses the register, then adds one, two or four by size.
// RL8: Postincrement of the stack pointer by a byte adds two.
// RL9: Predecrement subtracts one, two or four first and uses the result.
// RL10: Predecrement of the stack pointer by a byte subtracts two.
// RL11: Displacement mode adds a sign-extended 16-bit extension word to the register.
// RL12: Index mode adds register, sign-extended low eight bits and index register.
// RL13: Absolute short uses the sign-extended 16-bit extension word as address.
// RL14: Absolute long joins two extension words, first word is upper half.
// RL15: Counter displacement adds extension to its own address; program reference.
// RL16: Counter index adds extension address, low eight bits, index; program reference.
// RL17: Immediate byte is low byte, word one word, long two words upper first.
// RL18: In special modes the register field selects the special method.
// RL19: Logic immediate operations may target the condition byte or status word.
// RL20: Modes 000 to 110 are the register modes in order; 111 is special.
// RL21: Special codes 000 to 100 pick short, long, counter disp, counter index, immediate.
// RL22: Address register seven is the supervisor or user stack pointer by state.
// RL23: Mode sits in bits 5 to 3, register number in bits 2 to 0.
// RL24: Extension order is immediate words, then source, then destination extensions.
// RL25: Special mode with register codes 101, 110, 111 is illegal.
module ead_decoder
  import ead_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  // Operation word from the fetch path.
  input  wire logic        instr_valid_in,
  input  wire logic [15:0] op_word_in,
  input  wire logic [1:0]  op_size_in,
  input  wire logic [31:0] pc_in,
  input  wire logic        imm_src_in,
  input  wire logic        logic_imm_op_in,
  input  wire logic        jump_op_in,
  input  wire logic        op_write_in,
  input  wire logic        super_in,
  output var  logic        instr_ready_out,
  // Extension words.
  input  wire logic        ext_valid_in,
  input  wire logic [15:0] ext_word_in,
  output var  logic        ext_ready_out,
  // Register file read values and selects.
  input  wire logic [31:0] areg_val_in,
  input  wire logic [31:0] idx_val_in,
  output var  logic [3:0]  ea_reg_out,
  output var  logic [3:0]  idx_reg_out,
  output var  logic        sp_super_out,
  // Resolved operand.
  output var  logic        done_out,
  output var  ead_kind_e   ea_kind_out,
  output var  logic [31:0] ea_addr_out,
  output var  logic [31:0] imm_data_out,
  output var  logic        prog_ref_out,
  output var  logic        status_word_out,
  output var  logic        an_update_out,
  output var  logic [31:0] an_new_out,
  output var  logic [2:0]  len_out
);

  ead_state_e  state_r;
  ead_state_e  state_nxt;
  logic [15:0] words_r [4];
  logic [1:0]  cnt_r;
  logic [2:0]  need_r;
  logic [1:0]  imm_n_r;
  logic [2:0]  mode_r;
  logic [2:0]  reg_r;
  logic [1:0]  size_r;
  logic        jump_r;
  logic        write_r;
  logic        stat_r;
  logic        idx_long_r;
  logic [31:0] pc_r;
  logic        ready_r;
  logic        ext_ready_r;
  logic [3:0]  ea_reg_r;
  logic [3:0]  idx_reg_r;
  logic        sup_r;
  logic        done_r;
  ead_kind_e   kind_r;
  logic [31:0] addr_r;
  logic [31:0] imm_r;
  logic        prog_r;
  logic        sw_r;
  logic        upd_r;
  logic [31:0] new_r;
  logic [2:0]  len_r;

  // Decode of the arriving operation word.
  wire        take_w    = instr_valid_in && ready_r;
  wire [2:0]  op_mode_w = op_word_in[`EAD_MODE_HI:`EAD_MODE_LO]; // [RL4] [RL23]
  wire [2:0]  op_reg_w  = op_word_in[`EAD_REG_HI:`EAD_REG_LO];   // [RL4] [RL23]
  wire        spec_w    = op_mode_w == `EAD_MODE_SPEC;          // [RL20]
  wire        imm_fld_w = spec_w && op_reg_w == `EAD_SPEC_IMM;
  wire        stat_w    = imm_fld_w && logic_imm_op_in && imm_src_in; // [RL19]
  wire        ill_w     = spec_w && op_reg_w > `EAD_SPEC_IMM;   // [RL25]
  wire [1:0]  long_n_w  = (op_size_in == `EAD_SZ_LONG) ? 2'h2 : 2'h1;
  wire [1:0]  imm_n_w   = imm_src_in ? long_n_w : 2'h0;        // [RL2]
  wire        one_x_w   = op_mode_w == `EAD_MODE_DISP || op_mode_w == `EAD_MODE_INDEX;
  // Extension words the address field itself needs.
  wire [1:0]  ea_n_w    = one_x_w ? 2'h1 :                      // [RL11] [RL12]
                          !spec_w ? 2'h0 :
                          ill_w ? 2'h0 :
                          (op_reg_w == `EAD_SPEC_ABSL) ? 2'h2 :  // [RL14]
                          (op_reg_w == `EAD_SPEC_IMM) ? (stat_w ? 2'h0 : long_n_w) : // [RL17]
                          2'h1;                                  // [RL13] [RL15] [RL16]
  wire [2:0]  need_w    = {1'b0, imm_n_w} + {1'b0, ea_n_w};     // [RL1]
  wire        areg_m_w  = !spec_w && op_mode_w != `EAD_MODE_DREG;
  wire [3:0]  ea_sel_w  = spec_w ? 4'h0 : {areg_m_w, op_reg_w}; // [RL5] [RL18]
  wire        last_w    = ext_valid_in && ext_ready_r && ({1'b0, cnt_r} == need_r - 3'h1);

  // Words held for address formation; immediate words come first.
  wire [1:0]  ea_i0_w   = imm_n_r;                              // [RL24]
  wire [1:0]  ea_i1_w   = imm_n_r + 2'h1;
  wire [15:0] ea0_w     = words_r[ea_i0_w];
  wire [15:0] ea1_w     = words_r[ea_i1_w];
  wire [31:0] d16_w     = {{16{ea0_w[15]}}, ea0_w};
  wire [31:0] d8_w      = {{24{ea0_w[7]}}, ea0_w[7:0]};
  wire [31:0] idx_w     = idx_long_r ? idx_val_in : {{16{idx_val_in[15]}}, idx_val_in[15:0]};
  wire [31:0] pc_ext_w  = pc_r + `EAD_WORD_BYTES + {29'h0, imm_n_r, 1'b0};
  wire        sp_byte_w = reg_r == `EAD_SP_NUM;
  wire [31:0] step_w    = (size_r == `EAD_SZ_LONG) ? `EAD_STEP_L :
                          (size_r == `EAD_SZ_WORD || sp_byte_w) ? `EAD_STEP_W : // [RL8] [RL10]
                          `EAD_STEP_B;                                         // [RL7] [RL9]
  wire        sp_mode_w = mode_r == `EAD_MODE_SPEC;
  wire        pc_rel_w  = sp_mode_w && (reg_r == `EAD_SPEC_PCD || reg_r == `EAD_SPEC_PCX);
  wire        post_w    = mode_r == `EAD_MODE_POSTINC;
  wire        pre_w     = mode_r == `EAD_MODE_PREDEC;

  // Operand address by mode.
  wire [31:0] addr_w    = pre_w ? areg_val_in - step_w :                  // [RL9]
                          (mode_r == `EAD_MODE_DISP) ? areg_val_in + d16_w : // [RL11]
                          (mode_r == `EAD_MODE_INDEX) ? areg_val_in + d8_w + idx_w : // [RL12]
                          !sp_mode_w ? areg_val_in :                      // [RL7]
                          (reg_r == `EAD_SPEC_ABSW) ? d16_w :             // [RL13] [RL21]
                          (reg_r == `EAD_SPEC_ABSL) ? {ea0_w, ea1_w} :    // [RL14]
                          (reg_r == `EAD_SPEC_PCD) ? pc_ext_w + d16_w :   // [RL15]
                          (reg_r == `EAD_SPEC_PCX) ? pc_ext_w + d8_w + idx_w : // [RL16]
                          32'h0;
  wire [31:0] new_w     = post_w ? areg_val_in + step_w : areg_val_in - step_w;
  wire [31:0] imm_w     = (size_r == `EAD_SZ_BYTE) ? {24'h0, words_r[0][7:0]} : // [RL17]
                          (size_r == `EAD_SZ_WORD) ? {16'h0, words_r[0]} :
                          {words_r[0], words_r[1]};

  // Operand class; only memory modes can be program references.
  ead_kind_e  kind_w;
  assign kind_w = (mode_r == `EAD_MODE_DREG) ? EAD_K_DREG :  // [RL5]
                  (mode_r == `EAD_MODE_AREG) ? EAD_K_AREG :
                  !sp_mode_w ? EAD_K_MEM :
                  (reg_r > `EAD_SPEC_IMM) ? EAD_K_ILL :      // [RL25]
                  (reg_r != `EAD_SPEC_IMM) ? EAD_K_MEM :
                  stat_r ? EAD_K_STAT : EAD_K_IMM;           // [RL19]
  wire        mem_w     = kind_w == EAD_K_MEM;
  wire        jmp_cls_w = mem_w && !post_w && !pre_w && jump_r; // [RL6]
  wire        prog_w    = mem_w && !write_r && (pc_rel_w || jmp_cls_w); // [RL3] [RL15] [RL16]

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      EAD_ST_IDLE: begin
        if (take_w) begin
          state_nxt = (need_w == 3'h0) ? EAD_ST_CALC : EAD_ST_FETCH;
        end
      end
      EAD_ST_FETCH: begin
        if (last_w) begin
          state_nxt = EAD_ST_CALC;
        end
      end
      EAD_ST_CALC: begin
        state_nxt = EAD_ST_IDLE;
      end
      default: begin
        state_nxt = EAD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r     <= EAD_ST_IDLE;
      ready_r     <= 1'b0;
      ext_ready_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      ready_r     <= (state_nxt == EAD_ST_IDLE);
      ext_ready_r <= (state_nxt == EAD_ST_FETCH);
    end
  end

  // Instruction context latched when the operation word is taken.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      need_r   <= 3'h0;
      imm_n_r  <= 2'h0;
      mode_r   <= 3'h0;
      reg_r    <= 3'h0;
      size_r   <= 2'h0;
      jump_r   <= 1'b0;
      write_r  <= 1'b0;
      stat_r   <= 1'b0;
      pc_r     <= 32'h0;
      ea_reg_r <= 4'h0;
      sup_r    <= 1'b0;
    end else if (take_w) begin
      need_r   <= need_w;
      imm_n_r  <= imm_n_w;
      mode_r   <= op_mode_w;
      reg_r    <= op_reg_w;
      size_r   <= op_size_in;
      jump_r   <= jump_op_in;
      write_r  <= op_write_in;
      stat_r   <= stat_w;
      pc_r     <= pc_in;
      ea_reg_r <= ea_sel_w;
      sup_r    <= super_in; // [RL22]
    end
  end

  // Extension word capture in arrival order.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r      <= 2'h0;
      idx_reg_r  <= 4'h0;
      idx_long_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        words_r[i] <= 16'h0;
      end
    end else if (take_w) begin
      cnt_r <= 2'h0;
    end else if (ext_valid_in && ext_ready_r) begin
      words_r[cnt_r] <= ext_word_in; // [RL2] [RL24]
      cnt_r          <= cnt_r + 2'h1;
      if (last_w) begin
        idx_reg_r  <= {ext_word_in[`EAD_X_AREG], ext_word_in[`EAD_X_REG_HI:`EAD_X_REG_LO]};
        idx_long_r <= ext_word_in[`EAD_X_LONG];
      end
    end
  end

  // Result registers, loaded in the calculation cycle.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_r <= 1'b0;
      kind_r <= EAD_K_DREG;
      addr_r <= 32'h0;
      imm_r  <= 32'h0;
      prog_r <= 1'b0;
      sw_r   <= 1'b0;
      upd_r  <= 1'b0;
      new_r  <= 32'h0;
      len_r  <= 3'h0;
    end else begin
      done_r <= (state_r == EAD_ST_CALC);
      if (state_r == EAD_ST_CALC) begin
        kind_r <= kind_w;
        addr_r <= addr_w;
        imm_r  <= imm_w;
        prog_r <= prog_w;                               // [RL3] [RL6]
        sw_r   <= stat_r && size_r != `EAD_SZ_BYTE;     // [RL19]
        upd_r  <= post_w || pre_w;                      // [RL7] [RL9]
        new_r  <= new_w;
        len_r  <= need_r + 3'h1;                        // [RL1]
      end
    end
  end

  assign instr_ready_out = ready_r;
  assign ext_ready_out   = ext_ready_r;
  assign ea_reg_out      = ea_reg_r;
  assign idx_reg_out     = idx_reg_r;
  assign sp_super_out    = sup_r;
  assign done_out        = done_r;
  assign ea_kind_out     = kind_r;
  assign ea_addr_out     = addr_r;
  assign imm_data_out    = imm_r;
  assign prog_ref_out    = prog_r;
  assign status_word_out = sw_r;
  assign an_update_out   = upd_r;
  assign an_new_out      = new_r;
  assign len_out         = len_r;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  len_match_a: assert property (done_out |-> len_out == need_r + 3'h1 && len_out <= 3'h5) // [RL1]
    else $error("instruction length wrong");
  write_space_a: assert property (done_out && write_r |-> !prog_ref_out) // [RL3]
    else $error("write classified as program reference");
  postinc_word_a: assert property (done_out && post_w && size_r == `EAD_SZ_WORD // [RL7]
    |-> an_update_out && an_new_out == ea_addr_out + 32'h2)
    else $error("postincrement step wrong");
  sp_postinc_a: assert property (done_out && post_w && size_r == `EAD_SZ_BYTE // [RL8]
    |-> an_new_out == ea_addr_out + (sp_byte_w ? 32'h2 : 32'h1))
    else $error("stack pointer byte increment wrong");
  predec_addr_a: assert property (done_out && pre_w |-> an_update_out && an_new_out == ea_addr_out) // [RL9]
    else $error("predecrement address not the reduced value");
  absl_join_a: assert property (done_out && sp_mode_w && reg_r == `EAD_SPEC_ABSL // [RL14]
    |-> ea_addr_out == {ea0_w, ea1_w})
    else $error("absolute long address wrong");
  pc_prog_a: assert property (done_out && pc_rel_w |-> prog_ref_out == !write_r) // [RL15]
    else $error("counter relative not a program reference");
  illegal_mode_a: assert property (take_w && ill_w && !imm_src_in // [RL25]
    |-> ##2 done_out && ea_kind_out == EAD_K_ILL)
    else $error("illegal address field not flagged");
  sp_bank_a: assert property (take_w |=> sp_super_out == $past(super_in)) // [RL22]
    else $error("stack pointer bank not latched");

  postinc_c: cover property (done_out && post_w);
  pcx_c: cover property (done_out && pc_rel_w && reg_r == `EAD_SPEC_PCX);
  absl_c: cover property (done_out && len_out == 3'h5);
  illegal_c: cover property (done_out && ea_kind_out == EAD_K_ILL);

endmodule : ead_decoder
`default_nettype wire

//--- ead_fetch_model.sv
// Fetch side model: offers extension words and answers register file reads.
`timescale 1ns/100ps
`default_nettype none
module ead_fetch_model (
  // Clock, reset and word list.
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        load_in,
  input  wire logic [79:0] words_in,
  input  wire logic [2:0]  count_in,
  input  wire logic        slow_in,
  // Extension word handshake.
  input  wire logic        ext_ready_in,
  output var  logic        ext_valid_out,
  output var  logic [15:0] ext_word_out,
  // Register file reads.
  input  wire logic [3:0]  ea_reg_in,
  input  wire logic [3:0]  idx_reg_in,
  input  wire logic        sp_super_in,
  output var  logic [31:0] areg_val_out,
  output var  logic [31:0] idx_val_out
);
  logic [2:0]  pos_r;
  logic        gap_r;
  logic [15:0] last_r;
  logic [15:0] cur;
  logic        take;
  // Register 15 is the stack pointer; the supervisor copy differs from the user copy.
  function automatic logic [31:0] regv(input logic [3:0] r, input logic s);
    return 32'h0010_0000 + {20'h0, r, 8'h00} + ((r == 4'hF && s) ? 32'h0008_0000 : 32'h0);
  endfunction : regv
  assign cur           = words_in[16*(4-pos_r) +: 16];
  assign ext_valid_out = (pos_r < count_in) && !gap_r;
  assign take          = ext_valid_out && ext_ready_in;
  // An idle word line shows the inverse of the last word, never a stale copy.
  assign ext_word_out  = ext_valid_out ? cur : ~last_r;
  assign areg_val_out  = regv(ea_reg_in, sp_super_in);
  assign idx_val_out   = regv(idx_reg_in, sp_super_in);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pos_r  <= 3'h0;
      gap_r  <= 1'b0;
      last_r <= 16'h0;
    end else if (load_in) begin
      pos_r <= 3'h0;
      gap_r <= 1'b0;
    end else begin
      gap_r <= slow_in && take;
      if (take) begin
        pos_r  <= pos_r + 3'h1;
        last_r <= cur;
      end
    end
  end
endmodule : ead_fetch_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the effective address decoder.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ead_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        instr_valid_in = 1'b0;
  logic [15:0] op_word_in = 16'h0;
  logic [1:0]  op_size_in = 2'h0;
  logic [31:0] pc_in = 32'h0000_0400;
  logic        imm_src_in = 1'b0;
  logic        logic_imm_op_in = 1'b0;
  logic        jump_op_in = 1'b0;
  logic        op_write_in = 1'b0;
  logic        super_in = 1'b1;
  logic        load = 1'b0;
  logic        slow = 1'b0;
  logic [79:0] words = 80'h0;
  logic [2:0]  count = 3'h0;
  logic        instr_ready_out, ext_valid_in, ext_ready_out, sp_super_out, done_out;
  logic        prog_ref_out, status_word_out, an_update_out;
  logic [15:0] ext_word_in;
  logic [31:0] areg_val_in, idx_val_in, ea_addr_out, imm_data_out, an_new_out;
  logic [3:0]  ea_reg_out, idx_reg_out;
  logic [2:0]  len_out;
  ead_kind_e   ea_kind_out;
  int          error_cnt = 0;
  int          check_count = 0;

  always #20 ref_clk_in = ~ref_clk_in;

  ead_decoder DUT (
    .ref_clk_in, .nrst_in, .instr_valid_in, .op_word_in, .op_size_in, .pc_in, .imm_src_in,
    .logic_imm_op_in, .jump_op_in, .op_write_in, .super_in, .instr_ready_out, .ext_valid_in,
    .ext_word_in, .ext_ready_out, .areg_val_in, .idx_val_in, .ea_reg_out, .idx_reg_out,
    .sp_super_out, .done_out, .ea_kind_out, .ea_addr_out, .imm_data_out, .prog_ref_out,
    .status_word_out, .an_update_out, .an_new_out, .len_out
  );
  ead_fetch_model fetch (
    .clk_in(ref_clk_in), .nrst_in(nrst_in), .load_in(load), .words_in(words), .count_in(count),
    .slow_in(slow), .ext_ready_in(ext_ready_out), .ext_valid_out(ext_valid_in),
    .ext_word_out(ext_word_in), .ea_reg_in(ea_reg_out), .idx_reg_in(idx_reg_out),
    .sp_super_in(sp_super_out), .areg_val_out(areg_val_in), .idx_val_out(idx_val_in)
  );

  function automatic logic [31:0] regv(input logic [3:0] r, input logic s);
    return 32'h0010_0000 + {20'h0, r, 8'h00} + ((r == 4'hF && s) ? 32'h0008_0000 : 32'h0);
  endfunction : regv

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Offers one instruction and waits a bounded time for its result pulse.
  task automatic run(input logic [15:0] op, input logic [1:0] sz, input logic [3:0] fl,
                     input logic [79:0] w, input logic [2:0] n);
    int k;
    @(negedge ref_clk_in);
    op_word_in = op;
    op_size_in = sz;
    {imm_src_in, logic_imm_op_in, jump_op_in, op_write_in} = fl;
    words = w;
    count = n;
    instr_valid_in = 1'b1;
    load = 1'b1;
    @(negedge ref_clk_in);
    instr_valid_in = 1'b0;
    load = 1'b0;
    k = 0;
    while (done_out !== 1'b1 && k < 40) begin
      @(negedge ref_clk_in);
      k++;
    end
    chk("done", {31'h0, done_out}, 32'h1);
    chk("rdy", {31'h0, instr_ready_out}, 32'h1);
    chk("xrdy", {31'h0, ext_ready_out}, 32'h0);
  endtask : run

  task automatic res(input logic [31:0] a, input logic p, input logic [2:0] n);
    chk("kind", {29'h0, ea_kind_out}, {29'h0, EAD_K_MEM});
    chk("addr", ea_addr_out, a);
    chk("prog", {31'h0, prog_ref_out}, {31'h0, p});
    chk("len", {29'h0, len_out}, {29'h0, n});
  endtask : res

  task automatic t_direct();
    run(16'hC003, 2'h1, 4'h0, 80'h0, 3'h0);
    chk("kind", {29'h0, ea_kind_out}, {29'h0, EAD_K_DREG});
    chk("reg", {28'h0, ea_reg_out}, 32'h3);
    chk("len", {29'h0, len_out}, 32'h1);
    run(16'h000D, 2'h2, 4'h0, 80'h0, 3'h0);
    chk("kind", {29'h0, ea_kind_out}, {29'h0, EAD_K_AREG});
    chk("reg", {28'h0, ea_reg_out}, 32'hD);
    $display("test direct done");
  endtask : t_direct

  task automatic t_step();
    logic [31:0] st;
    for (int m = 0; m < 2; m++) begin
      super_in = m[0];
      for (int s = 0; s < 3; s++) begin
        st = (s == 0) ? 32'h1 : (s == 1) ? 32'h2 : 32'h4;
        run(m ? 16'h0022 : 16'h001A, s[1:0], 4'h2, 80'h0, 3'h0);
        chk("new", an_new_out, m ? regv(4'hA, m[0]) - st : regv(4'hA, m[0]) + st);
        chk("upd", {31'h0, an_update_out}, 32'h1);
        res(m ? regv(4'hA, m[0]) - st : regv(4'hA, m[0]), 1'b0, 3'h1);
      end
      run(m ? 16'h0027 : 16'h001F, 2'h0, 4'h0, 80'h0, 3'h0);
      chk("sp", an_new_out, m ? regv(4'hF, 1'b1) - 2 : regv(4'hF, 1'b0) + 2);
      chk("sps", {31'h0, sp_super_out}, {31'h0, m[0]});
    end
    $display("test step done");
  endtask : t_step

  task automatic t_disp();
    slow = 1'b1;
    run(16'h0029, 2'h1, 4'h0, {16'hFFF0, 64'h0}, 3'h1);
    res(regv(4'h9, 1'b1) - 32'h10, 1'b0, 3'h2);
    run(16'h0029, 2'h1, 4'h2, {16'h0010, 64'h0}, 3'h1);
    res(regv(4'h9, 1'b1) + 32'h10, 1'b1, 3'h2);
    run(16'h0029, 2'h1, 4'h3, {16'h0010, 64'h0}, 3'h1);
    res(regv(4'h9, 1'b1) + 32'h10, 1'b0, 3'h2);
    run(16'h0032, 2'h1, 4'h0, {16'hC880, 64'h0}, 3'h1);
    res(regv(4'hA, 1'b1) + regv(4'hC, 1'b1) - 32'h80, 1'b0, 3'h2);
    chk("idx", {28'h0, idx_reg_out}, 32'hC);
    run(16'h0032, 2'h1, 4'h0, {16'h3005, 64'h0}, 3'h1);
    res(regv(4'hA, 1'b1) + 32'h305, 1'b0, 3'h2);
    slow = 1'b0;
    $display("test displacement done");
  endtask : t_disp

  task automatic t_abs();
    run(16'h0038, 2'h1, 4'h2, {16'h8000, 64'h0}, 3'h1);
    res(32'hFFFF8000, 1'b1, 3'h2);
    chk("upd", {31'h0, an_update_out}, 32'h0);
    slow = 1'b1;
    run(16'h0039, 2'h1, 4'h0, {16'h1234, 16'h5678, 48'h0}, 3'h2);
    res(32'h12345678, 1'b0, 3'h3);
    slow = 1'b0;
    $display("test absolute done");
  endtask : t_abs

  task automatic t_pcrel();
    run(16'h003A, 2'h1, 4'h0, {16'h0010, 64'h0}, 3'h1);
    res(32'h0000_0412, 1'b1, 3'h2);
    run(16'h003B, 2'h1, 4'h0, {16'h10FE, 64'h0}, 3'h1);
    res(32'h0000_0500, 1'b1, 3'h2);
    run(16'h003A, 2'h1, 4'h8, {16'h1111, 16'h0010, 48'h0}, 3'h2);
    res(32'h0000_0414, 1'b1, 3'h3);
    chk("imm", imm_data_out, 32'h1111);
    $display("test counter relative done");
  endtask : t_pcrel

  task automatic t_imm();
    logic [31:0] ex [3];
    ex = '{32'h0000_00CD, 32'h0000_ABCD, 32'hABCD_5678};
    for (int s = 0; s < 3; s++) begin
      run(16'h003C, s[1:0], 4'h0, {16'hABCD, 16'h5678, 48'h0}, (s == 2) ? 3'h2 : 3'h1);
      chk("kind", {29'h0, ea_kind_out}, {29'h0, EAD_K_IMM});
      chk("imm", imm_data_out, ex[s]);
      chk("len", {29'h0, len_out}, (s == 2) ? 32'h3 : 32'h2);
    end
    run(16'h0039, 2'h2, 4'h8, {16'hAAAA, 16'hBBBB, 16'h1234, 16'h5678, 16'h0}, 3'h4);
    res(32'h12345678, 1'b0, 3'h5);
    chk("imm", imm_data_out, 32'hAAAABBBB);
    $display("test immediate done");
  endtask : t_imm

  task automatic t_special();
    for (int s = 0; s < 2; s++) begin
      run(16'h003C, s[1:0], 4'hC, {16'h00FF, 64'h0}, 3'h1);
      chk("kind", {29'h0, ea_kind_out}, {29'h0, EAD_K_STAT});
      chk("word", {31'h0, status_word_out}, s);
    end
    for (int r = 5; r < 8; r++) begin
      run(16'h0038 + r[15:0], 2'h1, 4'h0, 80'h0, 3'h0);
      chk("kind", {29'h0, ea_kind_out}, {29'h0, EAD_K_ILL});
      chk("len", {29'h0, len_out}, 32'h1);
    end
    $display("test special done");
  endtask : t_special

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  initial begin
    #400000;
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (10) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    chk("ready", {31'h0, instr_ready_out}, 32'h1);
    t_direct();
    t_step();
    t_disp();
    t_abs();
    t_pcrel();
    t_imm();
    t_special();
    close_out();
  end
endmodule : testbench
`default_nettype wire
